// [rtl/port_pkg.sv]
`default_nettype none
package port_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS         = 20;
    localparam int STEP_NS        = 1000;   // one gate step, one microsecond
    localparam int STEP_CYCLES    = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int GATE_PERIOD_US = 256;
    localparam int RTI_PERIOD_US  = 512;
    localparam int FINE_STEP_UV   = 500;    // output rise per fine-gate step
    localparam int CURRENT_RATIO  = 200;    // coarse current over fine current

    // ------------------------------------------------------------
    // register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_VOLT_HI   = 8'h00;
    localparam logic [7:0] OFS_VOLT_LO   = 8'h04;
    localparam logic [7:0] OFS_DIGIT2    = 8'h08;
    localparam logic [7:0] OFS_DIGIT3    = 8'h0c;
    localparam logic [7:0] OFS_LATCH     = 8'h10;
    localparam logic [7:0] OFS_LIMIT_SET = 8'h14;
    localparam logic [7:0] OFS_LIMIT_CLR = 8'h18;
    localparam logic [7:0] OFS_SEG_PORT  = 8'h1c;
    localparam logic [7:0] OFS_DIG_PORT  = 8'h20;
    localparam logic [7:0] OFS_BAL_PORT  = 8'h24;
    localparam logic [7:0] OFS_SWITCH    = 8'h28;
    localparam logic [7:0] OFS_STATUS    = 8'h2c;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // bit-addressable latch layout
    // ------------------------------------------------------------
    localparam int BIT_IDAC_DATA   = 0;
    localparam int BIT_IDAC_CLOCK  = 1;
    localparam int BIT_IDAC_STROBE = 2;
    localparam int BIT_IRQ_MASK    = 3;
    localparam int BIT_SHOW_VOLT   = 4;
    localparam int BIT_RELAY       = 5;
    localparam int BIT_LISTEN      = 6;
    localparam int BIT_REMOTE      = 7;
    localparam int LATCH_VALUE_BIT = 7;     // value travels on data bit 7
    localparam logic [7:0] LATCH_RESET = 8'h00;

    // pins arriving from outside the clock domain
    typedef struct packed {
        logic [6:0] segments;
        logic       measure_zero;
        logic [4:0] digit_scan;
        logic [2:0] select_buttons;
        logic [3:0] knob;
        logic       cv_mode;
        logic       cc_mode;
        logic       identify_button;
        logic       output_button;
        logic [7:0] address_switch;
        logic       force_mode;
        logic       listener_irq;
    } pin_in_type;

endpackage : port_pkg
`default_nettype wire

// [rtl/psu_io.sv]
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module psu_io #(
    parameter int STEP_CYCLES = port_pkg::STEP_CYCLES,
    parameter int GATE_STEPS  = port_pkg::GATE_PERIOD_US,
    parameter int RTI_STEPS   = port_pkg::RTI_PERIOD_US
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    // axi4-lite slave
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // panel and analog side
    input  wire port_pkg::pin_in_type  pins_in,
    output logic                       coarse_gate,
    output logic                       fine_gate,
    output logic [7:0]                 digit2_segments,
    output logic [7:0]                 digit3_segments,
    output logic                       idac_data,
    output logic                       idac_clock,
    output logic                       idac_strobe,
    output logic                       listen_indicator,
    output logic                       remote_indicator,
    output logic                       relay_on,
    output logic                       show_voltage_select,
    output logic                       show_limit_select,
    output logic                       periodic_irq_mask,
    output logic                       nmi_request,
    output logic                       irq_request,
    output logic                       bus_enable,
    output logic                       read_strobe,
    output logic                       write_strobe,
    output logic                       switch_enable
);

    // ------------------------------------------------------------
    // constants at the width of what they meet
    // ------------------------------------------------------------
    localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);
    localparam logic [15:0] STEP_HALF = 16'(STEP_CYCLES / 2);
    localparam logic [7:0]  GATE_LAST = 8'(GATE_STEPS - 1);
    localparam logic [9:0]  RTI_LAST  = 10'(RTI_STEPS - 1);

    typedef struct packed {
        port_pkg::pin_in_type sync1;
        port_pkg::pin_in_type sync2;
        port_pkg::pin_in_type sync3;
        port_pkg::pin_in_type pins;
        logic        awready;
        logic        wready;
        logic        arready;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  volt_hi;
        logic [7:0]  volt_lo;
        logic [7:0]  digit2;
        logic [7:0]  digit3;
        logic [7:0]  bit_latch;
        logic        show_limit;
        logic [15:0] step_cnt;
        logic        tick;
        logic [7:0]  gate_cnt;
        logic [7:0]  coarse_on;
        logic [7:0]  fine_on;
        logic        coarse_gate;
        logic        fine_gate;
        logic [9:0]  rti_cnt;
        logic        nmi;
        logic        irq;
        logic        bus_enable;
        logic        read_strobe;
        logic        write_strobe;
        logic        switch_enable;
    } state_type;

    state_type s;
    state_type next_s;

    // ------------------------------------------------------------
    // read decode: {error, word}
    // ------------------------------------------------------------
    function automatic logic [32:0] read_word(input state_type st,
                                              input logic [7:0] addr);
        logic        id_eff;
        logic [32:0] r;
        id_eff = st.pins.identify_button |
                 (st.show_limit & st.bit_latch[port_pkg::BIT_SHOW_VOLT]);
        r = '0;
        case (addr)
            port_pkg::OFS_VOLT_HI: r[7:0] = st.volt_hi;
            port_pkg::OFS_VOLT_LO: r[7:0] = st.volt_lo;
            port_pkg::OFS_DIGIT2:  r[7:0] = st.digit2;
            port_pkg::OFS_DIGIT3:  r[7:0] = st.digit3;
            port_pkg::OFS_LATCH:   r[7:0] = st.bit_latch;
            port_pkg::OFS_SEG_PORT: begin
                r[7:0] = {st.pins.measure_zero, st.pins.segments};
            end
            port_pkg::OFS_DIG_PORT: begin
                r[7:0] = {st.pins.select_buttons, st.pins.digit_scan};
            end
            port_pkg::OFS_BAL_PORT: begin
                r[7:0] = {st.pins.output_button, id_eff, st.pins.cc_mode,
                          st.pins.cv_mode, st.pins.knob};
            end
            port_pkg::OFS_SWITCH: r[7:0] = st.pins.address_switch;
            port_pkg::OFS_STATUS: begin
                r[3:0] = {st.pins.force_mode, st.irq, st.nmi, st.show_limit};
            end
            default: r[32] = 1'b1;
        endcase
        return r;
    endfunction : read_word

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        port_pkg::pin_in_type agree;
        logic [32:0] rd;
        next_s = s;
        agree = '0;
        rd = '0;
        next_s.read_strobe = 1'b0;
        next_s.write_strobe = 1'b0;
        next_s.switch_enable = 1'b0;

        // three-stage pin sync; value moves only when stages 2 and 3 agree
        next_s.sync1 = pins_in;
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        agree = ~(s.sync2 ^ s.sync3);
        next_s.pins = (agree & s.sync2) | (~agree & s.pins);

        next_s.tick = 1'b0;
        if (s.step_cnt == STEP_LAST) begin
            next_s.step_cnt = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.step_cnt = s.step_cnt + 16'h0001;
        end
        next_s.bus_enable = (s.step_cnt >= STEP_HALF);

        // fixed period, settings taken at wrap so no runt pulse
        if (s.tick) begin
            if (s.gate_cnt == GATE_LAST) begin
                next_s.gate_cnt = '0;
                next_s.coarse_on = s.volt_hi;
                next_s.fine_on = s.volt_lo;
            end else begin
                next_s.gate_cnt = s.gate_cnt + 8'h01;
            end
        end
        next_s.coarse_gate = (s.gate_cnt < s.coarse_on);
        next_s.fine_gate = (s.gate_cnt < s.fine_on);

        if (s.tick) begin
            if (s.rti_cnt == RTI_LAST) begin
                next_s.rti_cnt = '0;
            end else begin
                next_s.rti_cnt = s.rti_cnt + 10'h001;
            end
            next_s.nmi = (s.rti_cnt == RTI_LAST) &&
                         !s.bit_latch[port_pkg::BIT_IRQ_MASK];
        end

        next_s.irq = s.pins.listener_irq;

        // write channels taken in either order
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_held = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // writes act only under the write strobe
        if (s.aw_held && s.w_held) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = port_pkg::RESP_OKAY;
            next_s.write_strobe = 1'b1;
            case (s.aw_addr)
                port_pkg::OFS_VOLT_HI: begin
                    if (s.wstrb[0]) next_s.volt_hi = s.wdata[7:0];
                end
                port_pkg::OFS_VOLT_LO: begin
                    if (s.wstrb[0]) next_s.volt_lo = s.wdata[7:0];
                end
                port_pkg::OFS_DIGIT2: begin
                    if (s.wstrb[0]) next_s.digit2 = s.wdata[7:0];
                end
                port_pkg::OFS_DIGIT3: begin
                    if (s.wstrb[0]) next_s.digit3 = s.wdata[7:0];
                end
                // one bit, index in low bits
                port_pkg::OFS_LATCH: begin
                    if (s.wstrb[0]) begin
                        next_s.bit_latch[s.wdata[2:0]] =
                            s.wdata[port_pkg::LATCH_VALUE_BIT];
                    end
                end
                port_pkg::OFS_LIMIT_SET: begin
                    if (s.wstrb[0]) next_s.show_limit = 1'b1;
                end
                port_pkg::OFS_LIMIT_CLR: begin
                    if (s.wstrb[0]) next_s.show_limit = 1'b0;
                end
                default: next_s.bresp = port_pkg::RESP_SLVERR;
            endcase
        end

        // reads answer the cycle after the address is taken
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            rd = read_word(s, s_axi_araddr);
            next_s.rvalid = 1'b1;
            next_s.read_strobe = 1'b1;
            next_s.rdata = rd[31:0];
            next_s.rresp = rd[32] ? port_pkg::RESP_SLVERR : port_pkg::RESP_OKAY;
            // switch buffer on address or any forced read
            if (s.pins.force_mode || s_axi_araddr == port_pkg::OFS_SWITCH) begin
                next_s.switch_enable = 1'b1;
                next_s.rdata = {24'h000000, s.pins.address_switch};
                next_s.rresp = port_pkg::RESP_OKAY;
            end
        end

        // readies: one transfer of each kind under way at a time
        next_s.awready = !next_s.aw_held && !next_s.bvalid;
        next_s.wready = !next_s.w_held && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from state
    // ------------------------------------------------------------
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bresp = s.bresp;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rvalid = s.rvalid;
    assign coarse_gate = s.coarse_gate;
    assign fine_gate = s.fine_gate;
    assign digit2_segments = s.digit2;
    assign digit3_segments = s.digit3;
    assign idac_data = s.bit_latch[port_pkg::BIT_IDAC_DATA];
    assign idac_clock = s.bit_latch[port_pkg::BIT_IDAC_CLOCK];
    assign idac_strobe = s.bit_latch[port_pkg::BIT_IDAC_STROBE];
    assign listen_indicator = s.bit_latch[port_pkg::BIT_LISTEN];
    assign remote_indicator = s.bit_latch[port_pkg::BIT_REMOTE];
    assign relay_on = s.bit_latch[port_pkg::BIT_RELAY];
    assign show_voltage_select = s.bit_latch[port_pkg::BIT_SHOW_VOLT];
    assign periodic_irq_mask = s.bit_latch[port_pkg::BIT_IRQ_MASK];
    assign show_limit_select = s.show_limit;
    assign nmi_request = s.nmi;
    assign irq_request = s.irq;
    assign bus_enable = s.bus_enable;
    assign read_strobe = s.read_strobe;
    assign write_strobe = s.write_strobe;
    assign switch_enable = s.switch_enable;

endmodule : psu_io
`default_nettype wire

// [tb/psu_io_props.sv]
`timescale 1ns/1ns
`default_nettype none
module psu_io_props #(
    parameter int STEP_CYCLES = 50,
    parameter int GATE_STEPS  = 256,
    parameter int RTI_STEPS   = 512
) (
    input wire logic                 clock,
    input wire logic                 rst,
    input wire port_pkg::pin_in_type pins_in,
    input wire logic                 s_axi_bvalid,
    input wire logic                 s_axi_rvalid,
    input wire logic                 write_strobe,
    input wire logic                 read_strobe,
    input wire logic                 switch_enable,
    input wire logic                 nmi_request,
    input wire logic                 irq_request,
    input wire logic                 periodic_irq_mask,
    input wire logic                 fine_gate,
    input wire logic                 show_limit_select,
    input wire logic                 bus_enable
);
    localparam int STEP_LAST = STEP_CYCLES - 1;
    localparam int RTI_LAST  = RTI_STEPS * STEP_CYCLES - 1;
    localparam int GATE_CYC  = GATE_STEPS * STEP_CYCLES;
    logic        fine_q, seen;
    logic [31:0] gap;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ----
    // gate helper: cycles since the last fine-gate rise
    // ----
    always_ff @(posedge clock) begin
        fine_q <= rst ? 1'b0 : fine_gate;
        seen   <= !rst && (seen || (fine_gate && !fine_q));
        gap    <= (fine_gate && !fine_q) ? 32'h1 : gap + 32'h1;
    end
    chk_write_strobe_resp: assert property (write_strobe |-> $rose(s_axi_bvalid))
        else $error("write strobe without write response");
    chk_read_strobe_resp: assert property (read_strobe |-> $rose(s_axi_rvalid))
        else $error("read strobe without read data");
    chk_switch_on_read: assert property (switch_enable |-> read_strobe)
        else $error("switch buffer on outside a read");
    chk_bus_enable_period: assert property ($rose(bus_enable) |-> ##STEP_CYCLES $rose(bus_enable))
        else $error("bus enable period wrong");
    chk_limit_on_write: assert property ($changed(show_limit_select) |-> write_strobe)
        else $error("display select moved without a write");
    // a rise right after the mask drops may land mid-pulse, so those are skipped
    chk_nmi_width: assert property ($rose(nmi_request) && !periodic_irq_mask && !$past(periodic_irq_mask) |-> ##STEP_LAST (nmi_request || periodic_irq_mask) ##1 !nmi_request)
        else $error("periodic interrupt pulse width wrong");
    chk_nmi_period: assert property ($rose(nmi_request) && !periodic_irq_mask && !$past(periodic_irq_mask) && !$past(periodic_irq_mask, 2) |-> ##RTI_LAST (!nmi_request || periodic_irq_mask) ##1 (nmi_request || periodic_irq_mask))
        else $error("periodic interrupt spacing wrong");
    chk_nmi_masked: assert property (periodic_irq_mask && $past(periodic_irq_mask) |-> !$rose(nmi_request))
        else $error("periodic interrupt passed the mask");
    chk_irq_follows: assert property ($rose(pins_in.listener_irq) |-> ##[2:6] irq_request)
        else $error("listener request not passed on");
    chk_gate_period: assert property (fine_gate && !fine_q && seen |-> gap % GATE_CYC == 0)
        else $error("fine gate period not whole");
    chk_gate_step: assert property (!fine_gate && fine_q && seen |-> gap % STEP_CYCLES == 0)
        else $error("fine gate on time not whole steps");
endmodule : psu_io_props
bind psu_io psu_io_props #(.STEP_CYCLES(STEP_CYCLES), .GATE_STEPS(GATE_STEPS),
    .RTI_STEPS(RTI_STEPS)) chk (.clock, .rst, .pins_in, .s_axi_bvalid, .s_axi_rvalid,
    .write_strobe, .read_strobe, .switch_enable, .nmi_request, .irq_request,
    .periodic_irq_mask, .fine_gate, .show_limit_select, .bus_enable);
`default_nettype wire

// [tb/bus_master_model.sv]
`timescale 1ns/1ns
`default_nettype none
// processor side: one write and one read at most under way
module bus_master_model #(
    parameter logic [15:0] VOLT_OFFSET = 16'h0010
) (
    input  wire logic        clock,
    output logic [7:0]       awaddr = 8'h00,
    output logic             awvalid = 1'b0,
    input  wire logic        awready,
    output logic [31:0]      wdata = 32'h0,
    output logic [3:0]       wstrb = 4'hf,
    output logic             wvalid = 1'b0,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready = 1'b0,
    output logic [7:0]       araddr = 8'h00,
    output logic             arvalid = 1'b0,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready = 1'b0
);
    // address and data offered together, each dropped once taken
    task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : write
    // read address held until taken, rready until data arrive
    task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : read
    // offset added before loading; the word may wrap, the caller sees it
    task automatic set_voltage(input logic [15:0] v, output logic [15:0] w);
        logic [1:0] r;
        w = v + VOLT_OFFSET;
        write(port_pkg::OFS_VOLT_HI, {24'h0, w[15:8]}, r);
        write(port_pkg::OFS_VOLT_LO, {24'h0, w[7:0]}, r);
    endtask : set_voltage
endmodule : bus_master_model
`default_nettype wire

// [tb/io_ports_and_voltage_dac_pwm_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`define check_eq(what, exp, got) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("mismatch %s expected %h seen %h", what, exp, got); \
        end \
    end
module io_ports_and_voltage_dac_pwm_tb_top;
    localparam int STEP = 4;
    localparam int RTI  = 8;
    localparam int PER  = 256 * STEP;
    logic                 clock = 1'b0;
    logic                 rst = 1'b1;
    logic [7:0]           s_axi_awaddr, s_axi_araddr;
    logic                 s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [31:0]          s_axi_wdata;
    logic [3:0]           s_axi_wstrb;
    wire logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0]      s_axi_bresp, s_axi_rresp;
    wire logic [31:0]     s_axi_rdata;
    port_pkg::pin_in_type pins_in = '0;
    wire logic            coarse_gate, fine_gate, idac_data, idac_clock, idac_strobe, relay_on;
    wire logic            listen_indicator, remote_indicator, show_voltage_select, irq_request;
    wire logic            show_limit_select, periodic_irq_mask, nmi_request, bus_enable;
    wire logic            read_strobe, write_strobe, switch_enable;
    wire logic [7:0]      digit2_segments, digit3_segments, latch_out;
    int                   num_errors = 0;
    int                   tests_run = 0;
    int                   seed = 32'hc54e07a6;
    // ----
    // harness
    // ----
    psu_io #(.STEP_CYCLES(STEP), .GATE_STEPS(256), .RTI_STEPS(RTI)) uut (
        .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins_in, .coarse_gate, .fine_gate,
        .digit2_segments, .digit3_segments, .idac_data, .idac_clock, .idac_strobe,
        .listen_indicator, .remote_indicator, .relay_on, .show_voltage_select,
        .show_limit_select, .periodic_irq_mask, .nmi_request, .irq_request, .bus_enable,
        .read_strobe, .write_strobe, .switch_enable);
    bus_master_model bus (.clock, .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid),
        .awready(s_axi_awready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid), .wready(s_axi_wready), .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid), .bready(s_axi_bready), .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid), .arready(s_axi_arready), .rdata(s_axi_rdata),
        .rresp(s_axi_rresp), .rvalid(s_axi_rvalid), .rready(s_axi_rready));
    // latch outputs gathered in bit order
    assign latch_out = {remote_indicator, listen_indicator, relay_on, show_voltage_select,
                        periodic_irq_mask, idac_strobe, idac_clock, idac_data};
    always #10 clock = ~clock;
    // the only way out of the run
    task automatic results();
        $display("tests %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    // long enough for about 10k cycles of tests, with margin
    initial begin
        #(20 * 40000);
        num_errors++;
        results();
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
        logic [1:0] r;
        bus.write(a, d, r);
        `check_eq("bresp", exp, r)
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        bus.read(a, d, r);
        `check_eq("rresp", er, r)
        `check_eq("rdata", {24'h0, exp}, d)
    endtask : rd
    function automatic logic [7:0] bal_port(port_pkg::pin_in_type p, logic lim, logic sv);
        return {p.output_button, p.identify_button | (lim & sv), p.cc_mode, p.cv_mode, p.knob};
    endfunction : bal_port
    // gate on time over one whole period, waiting out the wrap latency first
    task automatic gates(input logic [15:0] v);
        logic [15:0] w;
        int          c = 0, f = 0;
        bus.set_voltage(v, w);
        repeat (2 * PER) @(posedge clock);
        repeat (PER) begin
            @(posedge clock);
            c += coarse_gate;
            f += fine_gate;
        end
        `check_eq("coarse_on", int'(w[15:8]) * STEP, c)
        `check_eq("fine_on", int'(w[7:0]) * STEP, f)
        $display("test gates %h done", w);
    endtask : gates
    initial begin
        logic [7:0]           lat;
        logic                 lim;
        logic [63:0]          r;
        port_pkg::pin_in_type p;
        int                   n;
        lat = 8'h00;
        lim = 1'b0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        for (int i = 0; i < 24; i++) begin
            r = {$random(seed), $random(seed)};
            lat[r[2:0]] = r[7];
            wr(port_pkg::OFS_LATCH, r[31:0], port_pkg::RESP_OKAY);
            `check_eq("latch", lat, latch_out)
        end
        rd(port_pkg::OFS_LATCH, lat, port_pkg::RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            r = {$random(seed), $random(seed)};
            wr(port_pkg::OFS_DIGIT2, r[31:0], port_pkg::RESP_OKAY);
            wr(port_pkg::OFS_DIGIT3, r[63:32], port_pkg::RESP_OKAY);
            `check_eq("digits", r[39:32], digit3_segments)
            `check_eq("digits", r[7:0], digit2_segments)
        end
        $display("test latches done");
        for (int i = 0; i < 5; i++) begin
            r = {$random(seed), $random(seed)};
            p = r[$bits(p)-1:0];
            p.force_mode = (i == 4);
            pins_in <= p;
            repeat (6) @(posedge clock);
            rd(port_pkg::OFS_SWITCH, p.address_switch, port_pkg::RESP_OKAY);
            if (i == 4) rd(port_pkg::OFS_DIG_PORT, p.address_switch, port_pkg::RESP_OKAY);
            if (i == 4) continue;
            rd(port_pkg::OFS_SEG_PORT, {p.measure_zero, p.segments}, port_pkg::RESP_OKAY);
            rd(port_pkg::OFS_DIG_PORT, {p.select_buttons, p.digit_scan}, port_pkg::RESP_OKAY);
            rd(port_pkg::OFS_BAL_PORT, bal_port(p, lim, lat[4]), port_pkg::RESP_OKAY);
            `check_eq("irq", p.listener_irq, irq_request)
        end
        p.force_mode = 1'b0;
        p.identify_button = 1'b0;
        pins_in <= p;
        wr(port_pkg::OFS_LATCH, 32'h84, port_pkg::RESP_OKAY);
        wr(port_pkg::OFS_LIMIT_SET, 32'h0, port_pkg::RESP_OKAY);
        `check_eq("limit", 1'b1, show_limit_select)
        rd(port_pkg::OFS_BAL_PORT, bal_port(p, 1'b1, 1'b1), port_pkg::RESP_OKAY);
        wr(port_pkg::OFS_LIMIT_CLR, 32'h0, port_pkg::RESP_OKAY);
        `check_eq("limit", 1'b0, show_limit_select)
        rd(port_pkg::OFS_BAL_PORT, bal_port(p, 1'b0, 1'b1), port_pkg::RESP_OKAY);
        rd(8'h30, 8'h00, port_pkg::RESP_SLVERR);
        wr(port_pkg::OFS_SEG_PORT, 32'hff, port_pkg::RESP_SLVERR);
        $display("test ports done");
        for (int m = 1; m >= 0; m--) begin
            wr(port_pkg::OFS_LATCH, {24'h0, m[0], 7'h03}, port_pkg::RESP_OKAY);
            repeat (STEP + 1) @(posedge clock);
            n = 0;
            repeat (2 * RTI * STEP) begin
                @(posedge clock);
                n += nmi_request;
            end
            `check_eq("nmi_high", (m == 1) ? 0 : 2 * STEP, n)
        end
        $display("test periodic done");
        gates(16'h0000);
        gates(16'hffef);
        gates(16'($random(seed)));
        results();
    end
endmodule : io_ports_and_voltage_dac_pwm_tb_top
`default_nettype wire
